// ===== src/ast_regs.vh
// Register map, field positions and timing constants of the serial transmitter
`ifndef AST_REGS_VH
`define AST_REGS_VH

`define AST_ADDR_W 6
`define AST_OFS_TXSTAT 6'h00
`define AST_OFS_RXSTAT 6'h04
`define AST_OFS_BAUDCTL 6'h08
`define AST_OFS_DIVLO 6'h0c
`define AST_OFS_DIVHI 6'h10
`define AST_OFS_TXHOLD 6'h14
`define AST_OFS_IRQFLG 6'h18
`define AST_OFS_IRQEN 6'h1c
`define AST_OFS_INTCTL 6'h20

`define AST_TXSTAT_NINE 6
`define AST_TXSTAT_SEND 5
`define AST_TXSTAT_SYNC 4
`define AST_TXSTAT_HSPD 2
`define AST_TXSTAT_EMPTY 1
`define AST_TXSTAT_BIT9 0
`define AST_RXSTAT_PORT 7
`define AST_BAUD_INV 4
`define AST_BAUD_WIDE 3
`define AST_IRQ_TX 4
`define AST_INTCTL_ALL 7
`define AST_INTCTL_PERI 6

`define AST_RST_BYTE 8'h00
`define AST_RST_DIV 8'h00
`define AST_FLAG_LAG 2
`define AST_CNT_W 22
`define AST_SHIFT_SLOW 5'd6
`define AST_SHIFT_MID 5'd4
`define AST_SHIFT_FAST 5'd2

`define AST_RESP_OKAY 2'b00
`define AST_RESP_SLVERR 2'b10

`endif

// ===== src/ast_tx.v
// Asynchronous serial transmitter with AXI4-Lite register access
// Functional notes
// [R1] Empty flag set while transmitter enabled and holding buffer empty.
// [R2] Flag clear only while shifter busy and another character is queued; here it is clear whenever a character is held or the transmitter is off.
// [R3] Flag reflects a holding-buffer write only two clocks after the write.
// [R4] Flag is read-only; writes to its bit position are ignored.
// [R5] Request needs the enable; the flag sets regardless of the enable.
// [R6] Software sets the enable only while more data remains to send.
// [R7] Shifter-empty bit set when idle, clears when a character is loaded.
// [R8] Shifter-empty stays clear until the stop bit has been fully sent.
// [R9] Shifter-empty bit feeds no interrupt; software polls it.
// [R10] The shift register has no software read or write path.
// [R11] Nine-bit enable sends nine data bits per character instead of eight.
// [R12] Ninth-bit field is the most significant data bit, sent last.
// [R13] Software writes the ninth bit before the holding buffer.
// [R14] All nine bits load together into a free shifter right after the write.
// [R15] A set ninth bit marks the character as an address byte.
// [R16] Software sets baud, enables port, picks modes, then enables tx.
// [R17] Enable set with empty buffer requests at once, given global enables.
// [R18] A holding-buffer write starts transmission once port and tx enabled.
// [R19] Divider 51 at 32 MHz in slow 8-bit mode gives about 9600 baud.
// [R20] Unimplemented register bits read back as zero.
// [R21] Frame is low start, data LSB first, high stop; line idles high.
// [R22] A character written while busy moves right after the stop bit.
// [R23] Inversion bit set inverts idle level and data bits on the line.
// [R24] Baud counter reloads from divider and advances once per bit period; here it counts down every clock and reloads at each bit boundary.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "ast_regs.vh"

module ast_tx
(
	input wire aclk,
	input wire aresetn,
	input wire [`AST_ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`AST_ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg tx_line_ff,
	output reg tx_line_oe_n_ff,
	output reg tx_irq_req_ff
);

	localparam ST_IDLE = 2'd0;
	localparam ST_START = 2'd1;
	localparam ST_DATA = 2'd2;
	localparam ST_STOP = 2'd3;

	// Register fields
	reg nine_bit_tx_enable_ff;
	reg transmitter_enable_ff;
	reg sync_mode_ff;
	reg high_speed_baud_select_ff;
	reg ninth_bit_data_ff;
	reg serial_port_enable_ff;
	reg polarity_invert_ff;
	reg wide_divider_select_ff;
	reg [7:0] baud_divider_low_ff;
	reg [7:0] baud_divider_high_ff;
	reg [7:0] tx_holding_buffer_ff;
	reg hold_bit9_ff;
	reg hold_full_ff;
	reg tx_irq_enable_ff;
	reg global_irq_enable_ff;
	reg peripheral_irq_enable_ff;
	reg [`AST_FLAG_LAG-1:0] flag_lag_ff;

	// Transmit engine
	reg [1:0] state_ff;
	reg [8:0] tx_shift_register_ff;
	reg [3:0] bits_left_ff;
	reg [`AST_CNT_W-1:0] baud_cnt_ff;

	// Bus capture
	reg aw_got_ff;
	reg w_got_ff;
	reg [`AST_ADDR_W-1:0] aw_addr_ff;
	reg [7:0] w_byte_ff;
	reg w_lane0_ff;

	wire aw_fire = s_axi_awvalid & s_axi_awready;
	wire w_fire = s_axi_wvalid & s_axi_wready;
	wire ar_fire = s_axi_arvalid & s_axi_arready;
	wire have_aw = aw_got_ff | aw_fire;
	wire have_w = w_got_ff | w_fire;
	wire [`AST_ADDR_W-1:0] wr_addr = aw_got_ff ? aw_addr_ff : s_axi_awaddr;
	wire [7:0] wr_byte = w_got_ff ? w_byte_ff : s_axi_wdata[7:0];
	wire wr_lane0 = w_got_ff ? w_lane0_ff : s_axi_wstrb[0];
	wire wr_do = have_aw & have_w & ~s_axi_bvalid;
	wire wr_en = wr_do & wr_lane0;

	wire async_on = transmitter_enable_ff & serial_port_enable_ff &
		~sync_mode_ff;
	wire hold_write = wr_en & (wr_addr == `AST_OFS_TXHOLD);
	wire shifter_free = (state_ff == ST_IDLE);
	wire load_shifter = async_on & hold_full_ff & shifter_free; // [R14] [R18]

	// Live empty condition; the readable flag lags it
	wire flag_now = transmitter_enable_ff & ~hold_full_ff; // [R1] [R2]
	wire flag_seen = flag_lag_ff[`AST_FLAG_LAG-1]; // [R3]

	// Bit period in clocks: (divider + 1) times 64, 16 or 4
	wire [15:0] div_val = wide_divider_select_ff ?
		{baud_divider_high_ff, baud_divider_low_ff} :
		{8'h00, baud_divider_low_ff};
	reg [4:0] nxt_shift;
	always @*
	begin
		if (wide_divider_select_ff & high_speed_baud_select_ff)
			nxt_shift = `AST_SHIFT_FAST;
		else if (wide_divider_select_ff | high_speed_baud_select_ff)
			nxt_shift = `AST_SHIFT_MID;
		else
			nxt_shift = `AST_SHIFT_SLOW; // [R19]
	end
	wire [`AST_CNT_W-1:0] div_plus = {6'h00, div_val} + 22'h000001;
	wire [`AST_CNT_W-1:0] bit_period = div_plus << nxt_shift;
	wire [`AST_CNT_W-1:0] bit_reload = bit_period - 22'h000001;
	wire bit_done = (baud_cnt_ff == 22'h000000);

	// Register and buffer writes
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			nine_bit_tx_enable_ff <= 1'b0;
			transmitter_enable_ff <= 1'b0;
			sync_mode_ff <= 1'b0;
			high_speed_baud_select_ff <= 1'b0;
			ninth_bit_data_ff <= 1'b0;
			serial_port_enable_ff <= 1'b0;
			polarity_invert_ff <= 1'b0;
			wide_divider_select_ff <= 1'b0;
			baud_divider_low_ff <= `AST_RST_DIV;
			baud_divider_high_ff <= `AST_RST_DIV;
			tx_irq_enable_ff <= 1'b0;
			global_irq_enable_ff <= 1'b0;
			peripheral_irq_enable_ff <= 1'b0;
		end
		else if (wr_en)
		begin
			if (wr_addr == `AST_OFS_TXSTAT)
			begin
				// Shifter-empty bit position is not writable
				nine_bit_tx_enable_ff <= wr_byte[`AST_TXSTAT_NINE];
				transmitter_enable_ff <= wr_byte[`AST_TXSTAT_SEND];
				sync_mode_ff <= wr_byte[`AST_TXSTAT_SYNC];
				high_speed_baud_select_ff <= wr_byte[`AST_TXSTAT_HSPD];
				ninth_bit_data_ff <= wr_byte[`AST_TXSTAT_BIT9];
			end
			else if (wr_addr == `AST_OFS_RXSTAT)
				serial_port_enable_ff <= wr_byte[`AST_RXSTAT_PORT];
			else if (wr_addr == `AST_OFS_BAUDCTL)
			begin
				polarity_invert_ff <= wr_byte[`AST_BAUD_INV];
				wide_divider_select_ff <= wr_byte[`AST_BAUD_WIDE];
			end
			else if (wr_addr == `AST_OFS_DIVLO)
				baud_divider_low_ff <= wr_byte;
			else if (wr_addr == `AST_OFS_DIVHI)
				baud_divider_high_ff <= wr_byte;
			else if (wr_addr == `AST_OFS_IRQEN)
				tx_irq_enable_ff <= wr_byte[`AST_IRQ_TX];
			else if (wr_addr == `AST_OFS_INTCTL)
			begin
				global_irq_enable_ff <= wr_byte[`AST_INTCTL_ALL];
				peripheral_irq_enable_ff <= wr_byte[`AST_INTCTL_PERI];
			end
			// Flag register writes are dropped entirely [R4]
		end
	end

	// Holding buffer: the ninth bit is sampled when the low byte commits
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_holding_buffer_ff <= `AST_RST_BYTE;
			hold_bit9_ff <= 1'b0;
			hold_full_ff <= 1'b0;
		end
		else
		begin
			if (hold_write)
			begin
				tx_holding_buffer_ff <= wr_byte;
				hold_bit9_ff <= ninth_bit_data_ff; // [R13]
			end
			// A new write wins over a same-cycle transfer to the shifter
			if (hold_write)
				hold_full_ff <= 1'b1;
			else if (!transmitter_enable_ff)
				hold_full_ff <= 1'b0;
			else if (load_shifter)
				hold_full_ff <= 1'b0; // [R22]
		end
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
			flag_lag_ff <= {`AST_FLAG_LAG{1'b0}};
		else
			flag_lag_ff <= {flag_lag_ff[`AST_FLAG_LAG-2:0], flag_now}; // [R3]
	end

	// Frame engine; the shift register is internal only [R10]
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff <= ST_IDLE;
			tx_shift_register_ff <= 9'h000;
			bits_left_ff <= 4'h0;
			baud_cnt_ff <= {`AST_CNT_W{1'b0}};
		end
		else if (!async_on)
		begin
			// Dropping the enable abandons any frame in flight
			state_ff <= ST_IDLE;
			bits_left_ff <= 4'h0;
			baud_cnt_ff <= {`AST_CNT_W{1'b0}};
		end
		else
		begin
			case (state_ff)
				ST_IDLE:
				begin
					if (load_shifter)
					begin
						tx_shift_register_ff <= {hold_bit9_ff,
							tx_holding_buffer_ff}; // [R14] [R15]
						bits_left_ff <= nine_bit_tx_enable_ff ?
							4'h9 : 4'h8; // [R11]
						baud_cnt_ff <= bit_reload; // [R24]
						state_ff <= ST_START; // [R7]
					end
				end
				ST_START:
				begin
					if (bit_done)
					begin
						baud_cnt_ff <= bit_reload;
						state_ff <= ST_DATA;
					end
					else
						baud_cnt_ff <= baud_cnt_ff - 22'h000001;
				end
				ST_DATA:
				begin
					if (bit_done)
					begin
						baud_cnt_ff <= bit_reload; // [R24]
						// LSB first, ninth bit ends up last [R12] [R21]
						tx_shift_register_ff <= {1'b0,
							tx_shift_register_ff[8:1]};
						bits_left_ff <= bits_left_ff - 4'h1;
						if (bits_left_ff == 4'h1)
							state_ff <= ST_STOP;
					end
					else
						baud_cnt_ff <= baud_cnt_ff - 22'h000001;
				end
				default:
				begin
					// Busy until the whole stop bit is out [R8]
					if (bit_done)
						state_ff <= ST_IDLE; // [R22]
					else
						baud_cnt_ff <= baud_cnt_ff - 22'h000001;
				end
			endcase
		end
	end

	// Line driver
	reg nxt_line;
	always @*
	begin
		case (state_ff)
			ST_START: nxt_line = 1'b0;
			ST_DATA: nxt_line = tx_shift_register_ff[0];
			default: nxt_line = 1'b1;
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_line_ff <= 1'b1;
			tx_line_oe_n_ff <= 1'b1;
			tx_irq_req_ff <= 1'b0;
		end
		else
		begin
			tx_line_ff <= nxt_line ^ polarity_invert_ff; // [R21] [R23]
			tx_line_oe_n_ff <= ~serial_port_enable_ff;
			// Only the buffer-empty flag reaches the request [R5] [R9] [R17]
			tx_irq_req_ff <= flag_seen & tx_irq_enable_ff &
				global_irq_enable_ff & peripheral_irq_enable_ff;
		end
	end

	// Read mux; bits without a field read zero [R20]
	reg [7:0] nxt_rbyte;
	reg nxt_rerr;
	always @*
	begin
		nxt_rbyte = 8'h00;
		nxt_rerr = 1'b0;
		if (s_axi_araddr == `AST_OFS_TXSTAT)
		begin
			nxt_rbyte[`AST_TXSTAT_NINE] = nine_bit_tx_enable_ff;
			nxt_rbyte[`AST_TXSTAT_SEND] = transmitter_enable_ff;
			nxt_rbyte[`AST_TXSTAT_SYNC] = sync_mode_ff;
			nxt_rbyte[`AST_TXSTAT_HSPD] = high_speed_baud_select_ff;
			nxt_rbyte[`AST_TXSTAT_EMPTY] = shifter_free; // [R7] [R8]
			nxt_rbyte[`AST_TXSTAT_BIT9] = ninth_bit_data_ff;
		end
		else if (s_axi_araddr == `AST_OFS_RXSTAT)
			nxt_rbyte[`AST_RXSTAT_PORT] = serial_port_enable_ff;
		else if (s_axi_araddr == `AST_OFS_BAUDCTL)
		begin
			nxt_rbyte[`AST_BAUD_INV] = polarity_invert_ff;
			nxt_rbyte[`AST_BAUD_WIDE] = wide_divider_select_ff;
		end
		else if (s_axi_araddr == `AST_OFS_DIVLO)
			nxt_rbyte = baud_divider_low_ff;
		else if (s_axi_araddr == `AST_OFS_DIVHI)
			nxt_rbyte = baud_divider_high_ff;
		else if (s_axi_araddr == `AST_OFS_TXHOLD)
			nxt_rbyte = tx_holding_buffer_ff;
		else if (s_axi_araddr == `AST_OFS_IRQFLG)
			nxt_rbyte[`AST_IRQ_TX] = flag_seen; // [R1] [R2] [R5]
		else if (s_axi_araddr == `AST_OFS_IRQEN)
			nxt_rbyte[`AST_IRQ_TX] = tx_irq_enable_ff;
		else if (s_axi_araddr == `AST_OFS_INTCTL)
		begin
			nxt_rbyte[`AST_INTCTL_ALL] = global_irq_enable_ff;
			nxt_rbyte[`AST_INTCTL_PERI] = peripheral_irq_enable_ff;
		end
		else
			nxt_rerr = 1'b1;
	end

	wire wr_mapped = (wr_addr == `AST_OFS_TXSTAT) |
		(wr_addr == `AST_OFS_RXSTAT) | (wr_addr == `AST_OFS_BAUDCTL) |
		(wr_addr == `AST_OFS_DIVLO) | (wr_addr == `AST_OFS_DIVHI) |
		(wr_addr == `AST_OFS_TXHOLD) | (wr_addr == `AST_OFS_IRQFLG) |
		(wr_addr == `AST_OFS_IRQEN) | (wr_addr == `AST_OFS_INTCTL);

	// Write channel: address and data taken in either order
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_addr_ff <= {`AST_ADDR_W{1'b0}};
			w_byte_ff <= 8'h00;
			w_lane0_ff <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AST_RESP_OKAY;
		end
		else
		begin
			if (aw_fire)
				aw_addr_ff <= s_axi_awaddr;
			if (w_fire)
			begin
				w_byte_ff <= s_axi_wdata[7:0];
				w_lane0_ff <= s_axi_wstrb[0];
			end
			if (wr_do)
			begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				s_axi_awready <= 1'b0;
				s_axi_wready <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? `AST_RESP_OKAY : `AST_RESP_SLVERR;
			end
			else
			begin
				if (aw_fire)
				begin
					aw_got_ff <= 1'b1;
					s_axi_awready <= 1'b0;
				end
				if (w_fire)
				begin
					w_got_ff <= 1'b1;
					s_axi_wready <= 1'b0;
				end
				if (s_axi_bvalid & s_axi_bready)
				begin
					s_axi_bvalid <= 1'b0;
					s_axi_awready <= 1'b1;
					s_axi_wready <= 1'b1;
				end
			end
		end
	end

	// Read channel: one read in flight
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `AST_RESP_OKAY;
		end
		else if (ar_fire)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, nxt_rbyte};
			s_axi_rresp <= nxt_rerr ? `AST_RESP_SLVERR : `AST_RESP_OKAY;
		end
		else if (s_axi_rvalid & s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // ast_tx

// ===== test/ast_rx_model.sv
// Behavioural far-end receiver that decodes frames off the serial line
`timescale 1ns/1ps

module ast_rx_model
(
	input wire aclk,
	input wire line,
	input wire en,
	input wire inv,
	input wire nine,
	input wire [15:0] per,
	output logic [8:0] data = 9'h000,
	output logic [7:0] cnt = 8'h00,
	output logic ferr = 1'h0
);
	logic [8:0] sh;
	// Samples mid-bit, so a clock of skew at the start edge is harmless
	always
	begin
		@(posedge aclk);
		if (en && (line ^ inv) === 1'h0)
		begin
			repeat (per / 2) @(posedge aclk);
			if ((line ^ inv) !== 1'h0)
				ferr = 1'h1;
			sh = 9'h000;
			for (int i = 0; i < (nine ? 9 : 8); i++)
			begin
				repeat (per) @(posedge aclk);
				sh[i] = line ^ inv;
			end
			repeat (per) @(posedge aclk);
			if ((line ^ inv) !== 1'h1)
				ferr = 1'h1;
			data = sh;
			cnt = cnt + 8'h01;
		end
	end
endmodule // ast_rx_model

// ===== test/ast_tx_checker.sv
// Concurrent checks on the serial transmitter's bus and line ports
`timescale 1ns/1ps
`include "ast_regs.vh"

module ast_tx_checker
(
	input wire aclk,
	input wire aresetn,
	input wire [`AST_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire tx_line_ff,
	input wire tx_line_oe_n_ff,
	input wire tx_irq_req_ff
);
	reg irq_en_ff;
	reg glb_en_ff;
	reg per_en_ff;
	wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Shadow of the enables, so a request can be tied to its cause
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_en_ff <= 1'h0;
			glb_en_ff <= 1'h0;
			per_en_ff <= 1'h0;
		end
		else if (wr_hs && s_axi_wstrb[0])
		begin
			if (s_axi_awaddr == `AST_OFS_IRQEN)
				irq_en_ff <= s_axi_wdata[`AST_IRQ_TX];
			if (s_axi_awaddr == `AST_OFS_INTCTL)
			begin
				glb_en_ff <= s_axi_wdata[`AST_INTCTL_ALL];
				per_en_ff <= s_axi_wdata[`AST_INTCTL_PERI];
			end
		end
	end
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_write_answer: assert property (wr_hs |=> s_axi_bvalid)
		else $error("write not answered");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read not answered");
	a_b_blocks_aw: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("write taken early");
	a_rdata_upper: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_irq_gated: assert property (
		tx_irq_req_ff |-> $past(irq_en_ff && glb_en_ff && per_en_ff))
		else $error("request without enables");
	a_reset_idle: assert property ($rose(aresetn) |->
		tx_line_ff && tx_line_oe_n_ff && !tx_irq_req_ff)
		else $error("line not idle after reset");
	// The flag only follows a buffer write two clocks later
	a_flag_lag: assert property (wr_hs && s_axi_wstrb[0] &&
		s_axi_awaddr == `AST_OFS_TXHOLD && tx_irq_req_ff |=> tx_irq_req_ff)
		else $error("request dropped at once after buffer write");
endmodule // ast_tx_checker

// ===== test/tb.sv
// Self-checking bench for the serial transmitter
`timescale 1ns/1ps
`include "ast_regs.vh"

module tb;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [5:0] s_axi_awaddr = 6'h00;
	logic s_axi_awvalid = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0;
	logic [5:0] s_axi_araddr = 6'h00;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, tx_line_ff, tx_line_oe_n_ff, tx_irq_req_ff;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	logic rx_en = 1'h0;
	logic rx_inv = 1'h0;
	logic rx_nine = 1'h0;
	logic [15:0] rx_per = 16'h0010;
	// Cycles the bus tasks wait before raising bready or rready
	int lag = 0;
	wire [8:0] rx_data;
	wire [7:0] rx_cnt;
	wire rx_ferr;
	int errors = 0;
	int compares = 0;
	logic [1:0] resp;
	logic [31:0] rdat;
	// Address, written byte, byte read back
	logic [21:0] rows [0:9] = '{{6'h00, 8'hff, 8'h77}, {6'h00, 8'h00, 8'h02},
		{6'h04, 8'hff, 8'h80}, {6'h04, 8'h00, 8'h00}, {6'h08, 8'hff, 8'h18},
		{6'h0c, 8'ha5, 8'ha5}, {6'h10, 8'h5a, 8'h5a}, {6'h18, 8'hff, 8'h00},
		{6'h1c, 8'hff, 8'h10}, {6'h20, 8'hff, 8'hc0}};
	always #2 aclk = ~aclk;

	ast_tx u_ast_tx
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.tx_line_ff, .tx_line_oe_n_ff, .tx_irq_req_ff
	);
	ast_rx_model u_ast_rx_model(.aclk, .line(tx_line_ff), .en(rx_en),
		.inv(rx_inv), .nine(rx_nine), .per(rx_per), .data(rx_data),
		.cnt(rx_cnt), .ferr(rx_ferr));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			errors++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask

	// Handshakes are judged at the negedge before the edge that takes them
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic aw, w, b;
		int n;
		b = 1'h0;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= (lag == 0);
		while (!b)
		begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid && s_axi_bready;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'h0;
			if (w)
				s_axi_wvalid <= 1'h0;
			n++;
			if (b)
				s_axi_bready <= 1'h0;
			else if (n >= lag)
				s_axi_bready <= 1'h1;
		end
	endtask

	task automatic rd(input logic [5:0] a);
		logic ar, r;
		int n;
		r = 1'h0;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= (lag == 0);
		while (!r)
		begin
			@(negedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid && s_axi_rready;
			rdat = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (ar)
				s_axi_arvalid <= 1'h0;
			n++;
			if (r)
				s_axi_rready <= 1'h0;
			else if (n >= lag)
				s_axi_rready <= 1'h1;
		end
	endtask

	task automatic rchk(input logic [5:0] a, input logic [7:0] e);
		rd(a);
		chk(rdat, {24'h0, e});
		chk({30'h0, resp}, {30'h0, `AST_RESP_OKAY});
	endtask

	task automatic wait_rx(input int n);
		int k;
		k = 0;
		while (rx_cnt < n && k < 4000)
		begin
			@(posedge aclk);
			k++;
		end
		chk({24'h0, rx_cnt}, n);
	endtask

	task automatic print_verdict;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge aclk);
		errors++;
		print_verdict;
	end

	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 10; i++)
		begin
			wr(rows[i][21:16], rows[i][15:8]);
			rchk(rows[i][21:16], rows[i][7:0]);
		end
		wr(6'h24, 8'h11);
		chk({30'h0, resp}, {30'h0, `AST_RESP_SLVERR});
		rd(6'h24);
		chk({30'h0, resp}, {30'h0, `AST_RESP_SLVERR});
		// Lane 0 off: answered, but the register keeps its value
		s_axi_wstrb <= 4'h0;
		wr(6'h0c, 8'hff);
		s_axi_wstrb <= 4'h1;
		chk({30'h0, resp}, {30'h0, `AST_RESP_OKAY});
		rchk(6'h0c, 8'ha5);
		// Late bready and rready: the answers must stand meanwhile
		lag = 3;
		wr(6'h0c, 8'h77);
		chk({30'h0, resp}, {30'h0, `AST_RESP_OKAY});
		rchk(6'h0c, 8'h77);
		lag = 0;
		// Divider 3, wide and fast selects: 16 clocks a bit
		wr(6'h0c, 8'h03);
		wr(6'h10, 8'h00);
		wr(6'h08, 8'h08);
		wr(6'h04, 8'h80);
		wr(6'h00, 8'h24);
		rx_en <= 1'h1;
		repeat (6) @(posedge aclk);
		chk(tx_irq_req_ff, 1'h1);
		chk(tx_line_oe_n_ff, 1'h0);
		rchk(6'h18, 8'h10);
		wr(6'h1c, 8'h00);
		repeat (3) @(posedge aclk);
		chk(tx_irq_req_ff, 1'h0);
		rchk(6'h18, 8'h10);
		wr(6'h14, 8'ha5);
		wr(6'h14, 8'h3c);
		repeat (3) @(posedge aclk);
		rchk(6'h18, 8'h00);
		rchk(6'h00, 8'h24);
		wait_rx(1);
		chk(rx_data, 9'h0a5);
		wait_rx(2);
		rchk(6'h00, 8'h24);
		chk(rx_data, 9'h03c);
		repeat (20) @(posedge aclk);
		rchk(6'h00, 8'h26);
		chk(tx_irq_req_ff, 1'h0);
		rx_nine <= 1'h1;
		for (int j = 0; j < 2; j++)
		begin
			repeat (20) @(posedge aclk);
			wr(6'h00, j ? 8'h64 : 8'h65);
			wr(6'h14, j ? 8'haa : 8'h55);
			wait_rx(3 + j);
			chk(rx_data, j ? 9'h0aa : 9'h155);
		end
		repeat (20) @(posedge aclk);
		rx_nine <= 1'h0;
		rx_per <= 16'h0040;
		// Slow select with divider 0, then wide only with divider 3
		wr(6'h0c, 8'h00);
		wr(6'h08, 8'h00);
		wr(6'h00, 8'h20);
		wr(6'h14, 8'hc3);
		wait_rx(5);
		chk(rx_data, 9'h0c3);
		repeat (40) @(posedge aclk);
		wr(6'h0c, 8'h03);
		wr(6'h08, 8'h08);
		wr(6'h14, 8'h5a);
		wait_rx(6);
		chk(rx_data, 9'h05a);
		repeat (40) @(posedge aclk);
		rx_en <= 1'h0;
		rx_per <= 16'h0010;
		wr(6'h00, 8'h24);
		wr(6'h08, 8'h18);
		repeat (4) @(posedge aclk);
		chk(tx_line_ff, 1'h0);
		rx_inv <= 1'h1;
		rx_en <= 1'h1;
		wr(6'h1c, 8'h10);
		wr(6'h14, 8'h96);
		wr(6'h1c, 8'h00);
		wait_rx(7);
		chk(rx_data, 9'h096);
		chk(rx_ferr, 1'h0);
		repeat (20) @(posedge aclk);
		rx_en <= 1'h0;
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		@(negedge aclk);
		chk({tx_line_ff, tx_line_oe_n_ff, tx_irq_req_ff}, 3'h6);
		rchk(6'h00, 8'h02);
		print_verdict;
	end
endmodule // tb

bind ast_tx ast_tx_checker u_ast_tx_checker(.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tx_line_ff,
	.tx_line_oe_n_ff, .tx_irq_req_ff);
